// ### pkg/ipc_pkg.sv
// constants and carrier types of the mezzanine carrier register bank
//
// Overview of operation
// - level register bits 2:0 pick bus level
// - error bit 0 reads OR of module errors
// - unused error and enable bits read zero
// - memory enable bit per module, D..A
// - reset clears all memory enable bits
// - io and id decode ignore memory enable
// - memory cycle passes only enabled, in window
// - base bits 7:4 compare address 23:20
// - size bits 3:2, reset 1MB base 0
// - base and size store all eight bits
// - request enable register, eight bits, reset zero
// - request raises irq with both enables set
// - global enable status bit 3, reset zero
// - pending shows requests regardless of enable
// - last serviced request gets lowest priority
// - writing one to clear drops pending
// - auto clear shows pending only while asserted
package ipc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS    = 8'hc1;
    localparam logic [7:0] OFS_LEVEL     = 8'hc3;
    localparam logic [7:0] OFS_ERROR     = 8'hc5;
    localparam logic [7:0] OFS_MEM_EN    = 8'hc7;
    localparam logic [7:0] OFS_BASE_A    = 8'hd1;
    localparam logic [7:0] OFS_BASE_STEP = 8'h02;
    localparam logic [7:0] OFS_IRQ_EN    = 8'he1;
    localparam logic [7:0] OFS_PENDING   = 8'he3;
    localparam logic [7:0] OFS_CLEAR     = 8'he5;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_ACE        = 7;
    localparam int BIT_GIE        = 3;
    localparam int BIT_GIP        = 2;
    localparam int BASE_MSB       = 7;
    localparam int BASE_LSB       = 4;
    localparam int SIZE_MSB       = 3;
    localparam int SIZE_LSB       = 2;
    localparam int LEVEL_MSB      = 2;
    localparam int NUM_MODULES    = 4;
    localparam int NUM_REQ        = 8;
    localparam int ADDR_HI_LSB    = 20;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [2:0] RST_LAST  = 3'h7;  // so bit 0 wins first
    localparam logic [3:0] FULL_MASK = 4'hf;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ipc_reg_req_t;

    typedef struct packed {
        logic        cycle;
        logic [23:0] addr;
    } ipc_mem_req_t;

    typedef struct packed {
        logic       cycle;
        logic [1:0] slot;
    } ipc_ioid_req_t;

endpackage : ipc_pkg

// ### hdl/ipc_win_dec.sv
// a24 memory window decode for the four mezzanine modules
`timescale 1ns/1ps
module ipc_win_dec
    import ipc_pkg::*;
#(
    parameter int MODS = NUM_MODULES
) (
    input  wire ipc_mem_req_t        mem_req,   // memory cycle and address
    input  wire logic [MODS-1:0][7:0] base_size, // base and size bytes
    input  wire logic [MODS-1:0]     mem_en,    // memory enable bits
    output logic      [MODS-1:0]     hit        // module window hit
);

    // ------------------------------------------------------------
    // window compare
    // ------------------------------------------------------------
    // larger sizes shift zeros into the mask so low base bits drop out
    function automatic logic win_match(input logic [7:0] bs, input logic [3:0] a_hi);
        logic [3:0] mask;
        mask = FULL_MASK << bs[SIZE_MSB:SIZE_LSB];
        return ((bs[BASE_MSB:BASE_LSB] ^ a_hi) & mask) == 4'h0;
    endfunction : win_match

    always_comb begin
        for (int m = 0; m < MODS; m++) begin
            hit[m] = mem_req.cycle && mem_en[m]
                     && win_match(base_size[m], mem_req.addr[23:ADDR_HI_LSB]);
        end
    end

endmodule : ipc_win_dec

// ### hdl/ipc_rr_arb.sv
// rotating priority pick among enabled pending requests
`timescale 1ns/1ps
module ipc_rr_arb
    import ipc_pkg::*;
(
    input  wire logic [7:0] req,    // enabled pending requests
    input  wire logic [2:0] last,   // index serviced most recently
    output logic      [2:0] win,    // chosen request index
    output logic            valid   // some request chosen
);

    // ------------------------------------------------------------
    // search from the slot after the last one, wrapping round
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] idx;
        idx   = 3'h0;
        win   = 3'h0;
        valid = 1'b0;
        for (int k = NUM_REQ; k >= 1; k--) begin
            idx = last + 3'(k);
            if (req[idx]) begin
                win   = idx;
                valid = 1'b1;
            end
        end
    end

endmodule : ipc_rr_arb

// ### hdl/ipc_carrier_regs.sv
// register bank, window decode and interrupt forwarding of the carrier
`timescale 1ns/1ps
module ipc_carrier_regs
    import ipc_pkg::*;
(
    input  wire logic          core_clk,       // board clock, 10 MHz
    input  wire logic          sys_rst,        // synchronous reset, high
    input  wire ipc_reg_req_t  reg_req,        // register byte access
    output logic [7:0]         reg_rdata,      // read data, one cycle later
    input  wire logic [3:0]    mod_error,      // module error lines, high
    input  wire logic [7:0]    mod_irq_req,    // module requests, pair per module
    input  wire ipc_mem_req_t  mem_req,        // a24 memory cycle
    output logic [3:0]         mem_sel,        // memory select per module
    input  wire ipc_ioid_req_t ioid_req,       // io or id space cycle
    output logic [3:0]         ioid_sel,       // io or id select per module
    input  wire logic          irq_serviced,   // pulse: chosen request acknowledged
    output logic               irq_out,        // bus interrupt request, high
    output logic [2:0]         irq_level,      // bus level for irq_out
    output logic [2:0]         irq_choice,     // request to be acknowledged next
    output logic               irq_choice_vld  // irq_choice is meaningful
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0][7:0] base_size;
        logic [3:0]      mem_en;
        logic [7:0]      irq_en;
        logic [7:0]      pend;
        logic [2:0]      level;
        logic            global_irq_enable;
        logic            ace;
        logic [2:0]      last;
        logic [7:0]      rdata;
        logic [3:0]      mem_sel;
        logic [3:0]      ioid_sel;
        logic            irq_out;
        logic [2:0]      choice;
        logic            choice_vld;
    } ipc_state_t;

    ipc_state_t st_q;
    ipc_state_t st_d;
    logic [3:0] win_hit;
    logic [2:0] arb_win;
    logic       arb_vld;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_wr(input ipc_reg_req_t r, input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction : is_wr

    function automatic logic is_rd(input ipc_reg_req_t r, input logic [7:0] ofs);
        return r.rd && (r.addr == ofs);
    endfunction : is_rd

    function automatic logic [7:0] base_ofs(input int m);
        return OFS_BASE_A + 8'(m) * OFS_BASE_STEP;
    endfunction : base_ofs

    // ------------------------------------------------------------
    // window decode and arbitration
    // ------------------------------------------------------------
    ipc_win_dec #(
        .MODS      (NUM_MODULES)
    ) u_win (
        .mem_req   (mem_req),
        .base_size (st_q.base_size),
        .mem_en    (st_q.mem_en),
        .hit       (win_hit)
    );

    // only enabled requests compete; pending alone does not
    ipc_rr_arb u_arb (
        .req   (st_q.pend & st_q.irq_en),
        .last  (st_q.last),
        .win   (arb_win),
        .valid (arb_vld)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rd_val;
        logic [7:0] clr;
        st_d   = st_q;
        rd_val = RST_BYTE;
        clr    = RST_BYTE;

        // register writes
        if (is_wr(reg_req, OFS_STATUS)) begin
            st_d.ace = reg_req.wdata[BIT_ACE];
            st_d.global_irq_enable = reg_req.wdata[BIT_GIE];
        end
        if (is_wr(reg_req, OFS_LEVEL)) begin
            st_d.level = reg_req.wdata[LEVEL_MSB:0];
        end
        if (is_wr(reg_req, OFS_MEM_EN)) begin
            st_d.mem_en = reg_req.wdata[NUM_MODULES-1:0];
        end
        for (int m = 0; m < NUM_MODULES; m++) begin
            if (is_wr(reg_req, base_ofs(m))) begin
                st_d.base_size[m] = reg_req.wdata;
            end
        end
        if (is_wr(reg_req, OFS_IRQ_EN)) begin
            st_d.irq_en = reg_req.wdata;
        end
        if (is_wr(reg_req, OFS_CLEAR)) begin
            clr = reg_req.wdata;
        end

        // pending: live in auto clear mode, else latched with set over clear
        if (st_q.ace) begin
            st_d.pend = mod_irq_req;
        end else begin
            st_d.pend = (st_q.pend & ~clr) | mod_irq_req;
        end

        // register reads, unmapped and write-only offsets read zero
        if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_STATUS: begin
                    rd_val[BIT_ACE] = st_q.ace;
                    rd_val[BIT_GIE] = st_q.global_irq_enable;
                    rd_val[BIT_GIP] = |st_q.pend;
                end
                OFS_LEVEL: begin
                    rd_val[LEVEL_MSB:0] = st_q.level;
                end
                OFS_ERROR: begin
                    rd_val[0] = |mod_error;
                end
                OFS_MEM_EN: begin
                    rd_val[NUM_MODULES-1:0] = st_q.mem_en;
                end
                OFS_IRQ_EN: begin
                    rd_val = st_q.irq_en;
                end
                OFS_PENDING: begin
                    rd_val = st_q.pend;
                end
                default: begin
                    for (int m = 0; m < NUM_MODULES; m++) begin
                        if (reg_req.addr == base_ofs(m)) begin
                            rd_val = st_q.base_size[m];
                        end
                    end
                end
            endcase
        end
        st_d.rdata = rd_val;

        // space selects; io and id never look at the memory enables
        st_d.mem_sel = win_hit;
        st_d.ioid_sel = RST_BYTE[3:0];
        if (ioid_req.cycle) begin
            st_d.ioid_sel[ioid_req.slot] = 1'b1;
        end

        // forwarding to the bus
        st_d.irq_out    = st_q.global_irq_enable && (|(st_q.pend & st_q.irq_en));
        st_d.choice     = arb_win;
        st_d.choice_vld = arb_vld;
        if (irq_serviced && st_q.choice_vld) begin
            st_d.last = st_q.choice;
        end

        if (sys_rst) begin
            st_d = '0;
            st_d.last = RST_LAST;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata      = st_q.rdata;
    assign mem_sel        = st_q.mem_sel;
    assign ioid_sel       = st_q.ioid_sel;
    assign irq_out        = st_q.irq_out;
    assign irq_level      = st_q.level;
    assign irq_choice     = st_q.choice;
    assign irq_choice_vld = st_q.choice_vld;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_level_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_wr(reg_req, OFS_LEVEL) |=> irq_level == $past(reg_req.wdata[LEVEL_MSB:0]))
        else $error("level register did not take written value");

    chk_error_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_rd(reg_req, OFS_ERROR) |=> reg_rdata == {7'h00, $past(|mod_error)})
        else $error("error register read wrong");

    chk_memen_unused: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_rd(reg_req, OFS_MEM_EN) |=> reg_rdata[7:4] == 4'h0)
        else $error("unused memory enable bits not zero");

    chk_memen_reset: assert property (@(posedge core_clk)
        sys_rst |=> st_q.mem_en == 4'h0 && st_q.base_size == '0)
        else $error("reset left memory enables or windows set");

    chk_mem_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mem_sel & ~$past(st_q.mem_en)) == 4'h0 && (mem_sel != 4'h0 -> $past(mem_req.cycle)))
        else $error("memory select without enable or cycle");

    chk_ioid_free: assert property (@(posedge core_clk) disable iff (sys_rst)
        ioid_req.cycle |=> ioid_sel[$past(ioid_req.slot)])
        else $error("io or id select blocked by memory enable");

    chk_base_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_wr(reg_req, OFS_BASE_A) ##1 is_rd(reg_req, OFS_BASE_A)
        |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("base register readback differs");

    chk_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq_out |-> $past(st_q.global_irq_enable) && ($past(st_q.pend & st_q.irq_en) != 8'h00))
        else $error("irq raised without both enables");

    chk_set_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
        !st_q.ace && mod_irq_req[0] |=> st_q.pend[0])
        else $error("request lost by pending latch");

    chk_clear_pend: assert property (@(posedge core_clk) disable iff (sys_rst)
        !st_q.ace && is_wr(reg_req, OFS_CLEAR) && reg_req.wdata[0] && !mod_irq_req[0]
        |=> !st_q.pend[0])
        else $error("clear did not drop pending bit");

    chk_ace_live: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_q.ace |=> st_q.pend == $past(mod_irq_req))
        else $error("pending latched while auto clear on");

    chk_rotate: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq_serviced && irq_choice_vld |=> st_q.last == $past(irq_choice))
        else $error("serviced request not moved to lowest priority");

    // ------------------------------------------------------------
    // checks on register storage and decode
    // ------------------------------------------------------------
    chk_memen_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_wr(reg_req, OFS_MEM_EN) |=> st_q.mem_en == $past(reg_req.wdata[NUM_MODULES-1:0]))
        else $error("memory enable did not take written value");

    chk_irqen_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_wr(reg_req, OFS_IRQ_EN) |=> st_q.irq_en == $past(reg_req.wdata))
        else $error("request enable did not take written value");

    chk_gie_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_wr(reg_req, OFS_STATUS) |=> st_q.global_irq_enable == $past(reg_req.wdata[BIT_GIE]))
        else $error("global enable did not take written value");

    chk_status_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_rd(reg_req, OFS_STATUS)
        |=> reg_rdata[BIT_GIE] == $past(st_q.global_irq_enable) && reg_rdata[BIT_GIP] == $past(|st_q.pend))
        else $error("status read shows wrong enable or pending");

    chk_pend_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_rd(reg_req, OFS_PENDING) |=> reg_rdata == $past(st_q.pend))
        else $error("pending register read wrong");

    chk_clear_wo: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_rd(reg_req, OFS_CLEAR) |=> reg_rdata == 8'h00)
        else $error("clear register read not zero");

    // an exact base match hits at every window size
    chk_mem_hit: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_req.cycle && st_q.mem_en[0]
        && mem_req.addr[23:ADDR_HI_LSB] == st_q.base_size[0][BASE_MSB:BASE_LSB] |=> mem_sel[0])
        else $error("enabled window not selected on base match");

    chk_ioid_onehot: assert property (@(posedge core_clk) disable iff (sys_rst)
        ioid_req.cycle |=> $onehot(ioid_sel))
        else $error("io or id select not one-hot");

    // ------------------------------------------------------------
    // checks on interrupt forwarding
    // ------------------------------------------------------------
    chk_pend_reset: assert property (@(posedge core_clk)
        sys_rst |=> st_q.pend == 8'h00 && st_q.irq_en == 8'h00 && !st_q.global_irq_enable)
        else $error("reset left pending or enables set");

    chk_irq_raise: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_q.global_irq_enable && (st_q.pend & st_q.irq_en) != 8'h00 |=> irq_out)
        else $error("enabled pending request not forwarded");

    // the pick must name a request that is both pending and enabled
    chk_choice_legal: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq_choice_vld |-> (($past(st_q.pend & st_q.irq_en) >> irq_choice) & 8'h01) == 8'h01)
        else $error("pick names a request that cannot be serviced");

    // a latched request only leaves through the clear register
    chk_pend_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        !st_q.ace && !is_wr(reg_req, OFS_CLEAR)
        |=> (st_q.pend & $past(st_q.pend)) == $past(st_q.pend))
        else $error("latched pending bit dropped without clear");

endmodule : ipc_carrier_regs

// ### tb/ipc_mod_model.sv
// behavioural stand-in for the four mezzanine modules
`timescale 1ns/1ps
module ipc_mod_model
    import ipc_pkg::*;
(
    input  wire logic       core_clk,       // board clock
    input  wire logic [7:0] req_set,        // request levels asked by the bench
    input  wire logic [3:0] err_set,        // error levels asked by the bench
    input  wire logic       ack_go,         // bench asks for one acknowledge
    input  wire logic       irq_out,        // carrier bus request
    input  wire logic       irq_choice_vld, // carrier holds a pick
    output logic      [7:0] mod_irq_req,    // request lines, pair per module
    output logic      [3:0] mod_error,      // error lines
    output logic            irq_serviced    // acknowledge pulse
);
    initial begin
        mod_irq_req  = 8'h00;
        mod_error    = 4'h0;
        irq_serviced = 1'b0;
    end
    // lines move just after the edge, as a module's own registers would
    always @(posedge core_clk) begin
        mod_irq_req  <= #1 req_set;
        mod_error    <= #1 err_set;
        // only acknowledge a request the carrier really raises; one pulse each
        irq_serviced <= #1 ack_go && irq_out && irq_choice_vld && !irq_serviced;
    end
endmodule : ipc_mod_model

// ### tb/testbench.sv
// self-checking bench of the carrier register bank
`timescale 1ns/1ps
module testbench;
    import ipc_pkg::*;
    logic          core_clk;
    logic          sys_rst;
    ipc_reg_req_t  reg_req;
    logic [7:0]    reg_rdata;
    ipc_mem_req_t  mem_req;
    logic [3:0]    mem_sel;
    ipc_ioid_req_t ioid_req;
    logic [3:0]    ioid_sel;
    logic [7:0]    mod_irq_req;
    logic [3:0]    mod_error;
    logic          irq_serviced;
    logic          irq_out;
    logic [2:0]    irq_level;
    logic [2:0]    irq_choice;
    logic          irq_choice_vld;
    logic [7:0]    req_set;
    logic [3:0]    err_set;
    logic          ack_go;
    int            fail_count;
    int            n_checks;
    // windows kept apart on purpose: A 1, B 2-3, C 4-7, D 8-f
    logic [7:0]    bs [4] = '{8'h10, 8'h34, 8'h48, 8'h8c};

    ipc_carrier_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .mod_error(mod_error), .mod_irq_req(mod_irq_req),
        .mem_req(mem_req), .mem_sel(mem_sel), .ioid_req(ioid_req), .ioid_sel(ioid_sel),
        .irq_serviced(irq_serviced), .irq_out(irq_out), .irq_level(irq_level),
        .irq_choice(irq_choice), .irq_choice_vld(irq_choice_vld));
    ipc_mod_model u_mods (.core_clk(core_clk), .req_set(req_set), .err_set(err_set),
        .ack_go(ack_go), .irq_out(irq_out), .irq_choice_vld(irq_choice_vld),
        .mod_irq_req(mod_irq_req), .mod_error(mod_error), .irq_serviced(irq_serviced));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic step(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        step();
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step();
        reg_req = '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        step();
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        step();
        reg_req = '0;
        check(reg_rdata, exp, "register read");
    endtask : reg_rd
    task automatic wait_irq(input logic exp);
        int i;
        for (i = 0; i < 10 && irq_out !== exp; i++) step();
        if (irq_out !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t irq_out wait ran out", $time);
            wrap_up();
        end
    endtask : wait_irq
    task automatic service();
        step();
        ack_go = 1'b1;
        step();
        ack_go = 1'b0;
        step(3);
    endtask : service
    function automatic logic [3:0] exp_sel(input logic [3:0] hi, input logic [3:0] en);
        logic [3:0] e;
        for (int m = 0; m < 4; m++) begin
            e[m] = en[m] && (((bs[m][7:4] ^ hi) & (4'hf << bs[m][3:2])) == 4'h0);
        end
        return e;
    endfunction : exp_sel
    task automatic mem_sweep(input logic [3:0] en);
        for (int h = 0; h < 16; h++) begin
            step();
            mem_req = '{cycle: 1'b1, addr: {h[3:0], 20'h5_a5a5}};
            step();
            mem_req = '0;
            check({4'h0, mem_sel}, {4'h0, exp_sel(h[3:0], en)}, "mem_sel");
        end
    endtask : mem_sweep

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        static logic [7:0] ofs [11] = '{OFS_STATUS, OFS_LEVEL, OFS_ERROR, OFS_MEM_EN, 8'hd1,
                                        8'hd3, 8'hd5, 8'hd7, OFS_IRQ_EN, OFS_PENDING, OFS_CLEAR};
        sys_rst = 1'b1;
        reg_req = '0;
        mem_req = '0;
        ioid_req = '0;
        req_set = 8'h00;
        err_set = 4'h0;
        ack_go = 1'b0;
        fail_count = 0;
        n_checks = 0;
        step(20);
        sys_rst = 1'b0;
        foreach (ofs[i]) reg_rd(ofs[i], 8'h00);
        reg_wr(8'hc9, 8'hff);
        reg_rd(8'hc9, 8'h00);
        reg_wr(OFS_LEVEL, 8'hff);
        reg_rd(OFS_LEVEL, 8'h07);
        reg_wr(OFS_LEVEL, 8'h05);
        check({5'h0, irq_level}, 8'h05, "irq_level");
        for (int i = 0; i < 4; i++) begin
            err_set = 4'h1 << i;
            reg_wr(OFS_ERROR, 8'hff);
            reg_rd(OFS_ERROR, 8'h01);
            err_set = 4'h0;
            step(2);
            reg_rd(OFS_ERROR, 8'h00);
        end
        reg_wr(OFS_MEM_EN, 8'hff);
        reg_rd(OFS_MEM_EN, 8'h0f);
        // write and read back to back, no idle cycle between them
        step();
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: OFS_BASE_A, wdata: 8'h5c};
        step();
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: OFS_BASE_A, wdata: 8'h00};
        step();
        reg_req = '0;
        check(reg_rdata, 8'h5c, "base write then read");
        for (int m = 0; m < 4; m++) begin
            reg_wr(OFS_BASE_A + 8'(m * 2), bs[m]);
            reg_rd(OFS_BASE_A + 8'(m * 2), bs[m]);
        end
        mem_sweep(4'hf);
        reg_wr(OFS_MEM_EN, 8'h0b);
        mem_sweep(4'hb);
        // io and id cycles run while some memory windows are open
        for (int s = 0; s < 4; s++) begin
            step();
            ioid_req = '{cycle: 1'b1, slot: s[1:0]};
            step();
            ioid_req = '0;
            check({4'h0, ioid_sel}, 8'h01 << s, "ioid_sel");
        end
        reg_wr(OFS_MEM_EN, 8'h00);
        mem_sweep(4'h0);
        reg_wr(OFS_IRQ_EN, 8'h05);
        req_set = 8'h05;
        step(3);
        reg_rd(OFS_PENDING, 8'h05);
        reg_rd(OFS_STATUS, 8'h04);
        check({7'h0, irq_out}, 8'h00, "irq_out gie off");
        reg_wr(OFS_IRQ_EN, 8'h00);
        reg_wr(OFS_STATUS, 8'h08);
        reg_rd(OFS_STATUS, 8'h0c);
        step(3);
        check({7'h0, irq_out}, 8'h00, "irq_out en off");
        reg_rd(OFS_PENDING, 8'h05);
        reg_wr(OFS_IRQ_EN, 8'h05);
        wait_irq(1'b1);
        check({7'h0, irq_choice_vld}, 8'h01, "pick valid");
        check({5'h0, irq_choice}, 8'h00, "first pick");
        service();
        check({5'h0, irq_choice}, 8'h02, "rotated pick");
        service();
        check({5'h0, irq_choice}, 8'h00, "wrapped pick");
        req_set = 8'h00;
        reg_wr(OFS_CLEAR, 8'h00);
        reg_rd(OFS_PENDING, 8'h05);
        reg_wr(OFS_CLEAR, 8'h05);
        wait_irq(1'b0);
        check({7'h0, irq_choice_vld}, 8'h00, "no pick left");
        for (int b = 0; b < 8; b++) begin
            req_set = 8'h01 << b;
            step(2);
            req_set = 8'h00;
            reg_rd(OFS_PENDING, 8'h01 << b);
            reg_wr(OFS_CLEAR, 8'h01 << b);
            reg_rd(OFS_PENDING, 8'h00);
        end
        reg_wr(OFS_STATUS, 8'h88);
        req_set = 8'h40;
        step(3);
        reg_rd(OFS_PENDING, 8'h40);
        reg_rd(OFS_STATUS, 8'h8c);
        req_set = 8'h00;
        step(3);
        reg_rd(OFS_PENDING, 8'h00);
        reg_wr(OFS_MEM_EN, 8'h0f);
        step();
        sys_rst = 1'b1;
        step();
        sys_rst = 1'b0;
        reg_rd(OFS_MEM_EN, 8'h00);
        reg_rd(8'hd3, 8'h00);
        reg_rd(OFS_STATUS, 8'h00);
        reg_rd(OFS_IRQ_EN, 8'h00);
        wrap_up();
    end
endmodule : testbench
